// ---- verilog/omc_top.sv ----
// oscillator run/stop, system clock select and cpu operating-mode sequencer
// assumes hosc_tick_i/lrc_tick_i are one-cycle enables on clock_i, one per
// oscillator cycle; port_lvl_i comes from pins and is synchronised here
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Operation
// (RULE_01) stop bit halts fast oscillator, slow rc runs
// (RULE_02) stop bit zero keeps fast source running
// (RULE_03) stop effect follows the high clock option
// (RULE_04) slow select bit picks slow rc clock
// (RULE_05) cpu mode field: normal, sleep, green, reserved
// (RULE_06) reset waits 2048 fast cycles warm-up
// (RULE_07) sleep wake waits 2048 crystal, 32 rc
// (RULE_08) exactly four modes: normal, slow, sleep, green
// (RULE_09) sleep stops all oscillators; green keeps clock
// (RULE_10) power-up waits 2048 slow rc cycles first
// (RULE_11) sleep wake clears sleep bit, normal mode
// (RULE_12) green wake clears the green bit
// (RULE_13) sleep exits only by port change, reset
// (RULE_14) green wakes by port or timer, returns
module omc_top
    import omc_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic clock_i, // 250 MHz system clock
    input wire logic resetn_i, // async reset, active low
    input wire logic [11:0] address_i, // avalon byte address
    input wire logic read_i, // avalon read
    input wire logic write_i, // avalon write
    input wire logic [3:0] byteenable_i, // avalon byte enables
    input wire logic [31:0] writedata_i, // avalon write data
    output logic [31:0] readdata_o, // avalon read data
    output logic waitrequest_o, // avalon wait request
    input wire logic [2:0] high_clk_option_i, // high clock option strap
    input wire logic hosc_tick_i, // one fast oscillator cycle
    input wire logic lrc_tick_i, // one slow rc cycle
    input wire logic [PORT_W-1:0] port_lvl_i, // wake-capable port pins
    input wire logic timer_wake_i, // wake-enabled timer overflow
    output logic internal_fast_rc_en_o, // internal fast rc enable
    output logic rtc_crystal_en_o, // 32768 Hz rtc crystal enable
    output logic external_fast_osc_en_o, // external fast oscillator enable
    output logic internal_slow_rc_en_o, // internal slow rc enable
    output logic slow_clock_select_o, // system clock from slow rc
    output logic cpu_run_o, // instruction execution allowed
    output logic [1:0] op_mode_o // omc_mode_e operating mode
);
    typedef enum logic [2:0] {ST_CONFIG, ST_WARM, ST_RUN, ST_SLEEP, ST_GREEN, ST_WAKE} omc_st_e;

    omc_st_e state_r;
    omc_opt_e opt_r;
    logic high_osc_stop_r;
    logic slow_clock_select_r;
    logic [1:0] cpu_mode_field_r;
    logic [11:0] cnt_r;
    logic [PORT_W-1:0] port_s1_r, port_s2_r, port_s3_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic req, hit, wr_fire, port_change, fast_on, xtal_opt, tick, cnt_last;
    logic [11:0] cnt_target;

    // true when the option drives an external crystal or resonator
    function automatic logic is_xtal(input omc_opt_e o);
        return (o == OMC_OPT_XTAL_32K) || (o == OMC_OPT_XTAL_12M) || (o == OMC_OPT_XTAL_4M);
    endfunction : is_xtal

    // bus slave: one wait state, data registered for the accepting edge
    // a write lands only on the accepting edge, when waitrequest is low
    assign req = read_i | write_i;
    assign hit = (address_i == OMC_MODE_ADDR);
    assign waitrequest_o = req & ~ack_r;
    assign wr_fire = write_i & ack_r & hit & byteenable_i[0];
    assign readdata_o = readdata_r;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            readdata_r <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            if (read_i & ~ack_r) begin
                readdata_r <= hit ? {24'h0, 3'h0, cpu_mode_field_r, slow_clock_select_r,
                                     high_osc_stop_r, 1'b0} : 32'h0;
            end
        end
    end

    // option strap sampled on every cycle while configuring, held once warm-up starts
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            opt_r <= OMC_OPT_FAST_ONLY;
        end else if (state_r == ST_CONFIG) begin
            opt_r <= omc_opt_e'(high_clk_option_i);
        end
    end

    // port level-change detect behind a two-stage synchroniser
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_s1_r <= '0;
            port_s2_r <= '0;
            port_s3_r <= '0;
        end else begin
            port_s1_r <= port_lvl_i;
            port_s2_r <= port_s1_r;
            port_s3_r <= port_s2_r;
        end
    end
    assign port_change = |(port_s2_r ^ port_s3_r);

    // warm-up and configuration counting
    assign xtal_opt = is_xtal(opt_r);
    assign tick = (state_r == ST_CONFIG) ? lrc_tick_i : hosc_tick_i;
    always_comb begin
        case (state_r)
            ST_CONFIG: cnt_target = OMC_CFG_CYC; // RULE_10
            ST_WAKE: cnt_target = xtal_opt ? OMC_WARM_XTAL_CYC : OMC_WARM_RC_CYC; // RULE_07
            default: cnt_target = OMC_WARM_XTAL_CYC; // RULE_06
        endcase
    end
    assign cnt_last = tick && (cnt_r == cnt_target - 12'h001);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 12'h0;
        end else if (state_r != ST_CONFIG && state_r != ST_WARM && state_r != ST_WAKE) begin
            cnt_r <= 12'h0;
        end else if (cnt_last) begin
            cnt_r <= 12'h0;
        end else if (tick) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    // operating-mode sequencer
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_CONFIG;
        end else begin
            case (state_r)
                ST_CONFIG: if (cnt_last) state_r <= ST_WARM; // RULE_10
                ST_WARM: if (cnt_last) state_r <= ST_RUN; // RULE_06
                ST_RUN: begin
                    if (cpu_mode_field_r == OMC_CPUM_SLEEP) begin
                        state_r <= ST_SLEEP; // RULE_05
                    end else if (cpu_mode_field_r == OMC_CPUM_GREEN) begin
                        state_r <= ST_GREEN; // RULE_05
                    end
                end
                ST_SLEEP: if (port_change) state_r <= ST_WAKE; // RULE_13
                ST_WAKE: if (cnt_last) state_r <= ST_RUN; // RULE_07
                ST_GREEN: if (port_change || timer_wake_i) state_r <= ST_RUN; // RULE_14
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // control register; a software write in the same cycle wins over hardware clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {cpu_mode_field_r, slow_clock_select_r, high_osc_stop_r} <= OMC_MODE_RESET[4:1];
        end else if (wr_fire) begin
            high_osc_stop_r <= writedata_i[OMC_STOP_BIT];
            slow_clock_select_r <= writedata_i[OMC_SLOW_BIT];
            cpu_mode_field_r <= writedata_i[OMC_CPUM_HI:OMC_CPUM_LO];
        end else if (state_r == ST_SLEEP && port_change) begin
            cpu_mode_field_r[0] <= 1'b0; // RULE_11
            slow_clock_select_r <= 1'b0; // RULE_11
            high_osc_stop_r <= 1'b0; // RULE_11
        end else if (state_r == ST_GREEN && (port_change || timer_wake_i)) begin
            cpu_mode_field_r[1] <= 1'b0; // RULE_12
        end
    end

    // oscillator enables per mode and option
    always_comb begin
        case (state_r)
            ST_CONFIG: fast_on = 1'b0;
            ST_WARM, ST_WAKE: fast_on = 1'b1;
            ST_SLEEP: fast_on = 1'b0; // RULE_09
            default: fast_on = ~high_osc_stop_r; // RULE_01 RULE_02
        endcase
    end
    assign internal_fast_rc_en_o = fast_on &&
        (opt_r == OMC_OPT_FAST_ONLY || opt_r == OMC_OPT_FAST_RTC); // RULE_03
    assign rtc_crystal_en_o = fast_on && (opt_r == OMC_OPT_FAST_RTC); // RULE_03
    assign external_fast_osc_en_o = fast_on &&
        (opt_r != OMC_OPT_FAST_ONLY) && (opt_r != OMC_OPT_FAST_RTC); // RULE_03
    assign internal_slow_rc_en_o = (state_r != ST_SLEEP); // RULE_01 RULE_09
    assign slow_clock_select_o = slow_clock_select_r; // RULE_04
    assign cpu_run_o = (state_r == ST_RUN); // RULE_09
    always_comb begin
        case (state_r)
            ST_SLEEP: op_mode_o = OMC_MODE_PDOWN; // RULE_08
            ST_GREEN: op_mode_o = OMC_MODE_GREEN;
            default: op_mode_o = slow_clock_select_r ? OMC_MODE_SLOW : OMC_MODE_NORMAL;
        endcase
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_stop_halts_fast: assert property ((state_r == ST_RUN) && high_osc_stop_r |->
        !internal_fast_rc_en_o && !external_fast_osc_en_o && internal_slow_rc_en_o) // RULE_01
        else $error("stop bit did not halt fast oscillator");
    a_run_keeps_fast: assert property ((state_r == ST_RUN) && !high_osc_stop_r |->
        (internal_fast_rc_en_o || external_fast_osc_en_o)) // RULE_02
        else $error("fast oscillator off with stop bit clear");
    a_option_map: assert property ((opt_r == OMC_OPT_FAST_ONLY) |->
        !external_fast_osc_en_o && !rtc_crystal_en_o) // RULE_03
        else $error("wrong oscillator for fast-only option");
    a_slow_mode_out: assert property ((state_r == ST_RUN) && slow_clock_select_r |->
        slow_clock_select_o && op_mode_o == OMC_MODE_SLOW) // RULE_04
        else $error("slow select not reflected");
    a_sleep_decode: assert property ((state_r == ST_RUN) && cpu_mode_field_r == OMC_CPUM_SLEEP
        |=> (state_r == ST_SLEEP) ##0 !cpu_run_o) // RULE_05
        else $error("sleep code did not enter sleep");
    a_reset_warm_end: assert property ((state_r == ST_WARM) && hosc_tick_i && cnt_r == 12'h7ff
        |=> state_r == ST_RUN) // RULE_06
        else $error("reset warm-up length wrong");
    a_rc_wake_len: assert property ((state_r == ST_WAKE) && !xtal_opt && hosc_tick_i &&
        cnt_r == 12'h01f |=> state_r == ST_RUN) // RULE_07
        else $error("rc wake warm-up length wrong");
    a_sleep_all_off: assert property ((state_r == ST_SLEEP) |-> !internal_slow_rc_en_o &&
        !internal_fast_rc_en_o && !external_fast_osc_en_o && !cpu_run_o) // RULE_09
        else $error("oscillator running in sleep");
    a_sleep_wake_clr: assert property ((state_r == ST_SLEEP) && port_change && !wr_fire
        |=> state_r == ST_WAKE && !cpu_mode_field_r[0] && !slow_clock_select_r) // RULE_11
        else $error("sleep wake did not clear mode");
    a_green_return: assert property ((state_r == ST_GREEN) && timer_wake_i && !wr_fire
        |=> state_r == ST_RUN && !cpu_mode_field_r[1] &&
            slow_clock_select_r == $past(slow_clock_select_r)) // RULE_12
        else $error("green wake did not return");
    c_sleep_wake: cover property ((state_r == ST_WAKE) ##1 (state_r == ST_RUN));
    c_green_wake: cover property ((state_r == ST_GREEN) ##1 (state_r == ST_RUN));
    c_slow_run: cover property ((state_r == ST_RUN) && slow_clock_select_r && high_osc_stop_r);
endmodule : omc_top

// ---- verilog/omc_pkg.sv ----
// oscillator and operating-mode control: shared constants and types
// assumes a single 250 MHz system clock; oscillator cycles arrive as enable pulses
package omc_pkg;
    // register index as printed, byte address is four times the index
    localparam logic [11:0] OMC_MODE_IDX = 12'h0ca;
    localparam logic [11:0] OMC_MODE_ADDR = 12'(OMC_MODE_IDX << 2);
    localparam logic [7:0] OMC_MODE_RESET = 8'h00;
    localparam logic [7:0] OMC_MODE_WMASK = 8'h1e;
    // field positions
    localparam int OMC_STOP_BIT = 1;
    localparam int OMC_SLOW_BIT = 2;
    localparam int OMC_CPUM_LO = 3;
    localparam int OMC_CPUM_HI = 4;
    // cpu mode field encodings
    localparam logic [1:0] OMC_CPUM_NORMAL = 2'h0;
    localparam logic [1:0] OMC_CPUM_SLEEP = 2'h1;
    localparam logic [1:0] OMC_CPUM_GREEN = 2'h2;
    // timing counts, in oscillator cycles
    localparam logic [11:0] OMC_CFG_CYC = 12'h800;
    localparam logic [11:0] OMC_WARM_XTAL_CYC = 12'h800;
    localparam logic [11:0] OMC_WARM_RC_CYC = 12'h020;
    // high clock configuration option
    typedef enum logic [2:0] {
        OMC_OPT_FAST_ONLY,
        OMC_OPT_FAST_RTC,
        OMC_OPT_EXT_RC,
        OMC_OPT_XTAL_32K,
        OMC_OPT_XTAL_12M,
        OMC_OPT_XTAL_4M
    } omc_opt_e;
    // operating mode reported to the system
    typedef enum logic [1:0] {
        OMC_MODE_NORMAL,
        OMC_MODE_SLOW,
        OMC_MODE_GREEN,
        OMC_MODE_PDOWN
    } omc_mode_e;
endpackage : omc_pkg

// ---- tb/test_oscillator_mode_control.sv ----
// self-checking bench for the oscillator and operating-mode control block
// assumes omc_pkg and omc_top are compiled first; oscillator ticks are driven every cycle only while the tick task runs
`timescale 1ns/1ns
module test_oscillator_mode_control
    import omc_pkg::*;
;
    logic clock_i, resetn_i, read_i, write_i, hosc_tick_i, lrc_tick_i, timer_wake_i;
    logic [11:0] address_i;
    logic [3:0] byteenable_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic waitrequest_o, fast_rc, rtc_en, ext_en, slow_rc, slow_sel, cpu_run_o;
    logic [2:0] high_clk_option_i;
    logic [7:0] port_lvl_i;
    logic [1:0] op_mode_o;
    int errors, check_count, o, n;
    omc_top #(.PORT_W(8)) omc_top_i (.clock_i(clock_i), .resetn_i(resetn_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .high_clk_option_i(high_clk_option_i),
        .hosc_tick_i(hosc_tick_i), .lrc_tick_i(lrc_tick_i), .port_lvl_i(port_lvl_i),
        .timer_wake_i(timer_wake_i), .internal_fast_rc_en_o(fast_rc),
        .rtc_crystal_en_o(rtc_en), .external_fast_osc_en_o(ext_en),
        .internal_slow_rc_en_o(slow_rc), .slow_clock_select_o(slow_sel),
        .cpu_run_o(cpu_run_o), .op_mode_o(op_mode_o));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= ~wr;
        do begin
            @(posedge clock_i);
            k++;
        end while (waitrequest_o !== 1'b0 && k < 20);
        // waitrequest and read data are the values sampled at this rising edge
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (waitrequest_o !== 1'b0) begin
            chk(1'b1, 1'b0, "bus timeout");
            tally_and_finish();
        end
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp, "register read");
    endtask : rd
    task automatic tick(input logic slow, input int cnt);
        repeat (cnt) begin
            @(posedge clock_i);
            lrc_tick_i <= slow;
            hosc_tick_i <= ~slow;
        end
        @(posedge clock_i);
        lrc_tick_i <= 1'b0;
        hosc_tick_i <= 1'b0;
        @(negedge clock_i);
    endtask : tick
    task automatic pulse_timer;
        @(posedge clock_i);
        timer_wake_i <= 1'b1;
        @(posedge clock_i);
        timer_wake_i <= 1'b0;
    endtask : pulse_timer
    task automatic wait_run;
        int k;
        for (k = 0; k < 50 && cpu_run_o !== 1'b1; k++) @(negedge clock_i);
        chk(cpu_run_o, 1'b1, "wake to run");
        if (k >= 50) tally_and_finish();
    endtask : wait_run
    initial begin
        errors = 0;
        check_count = 0;
        resetn_i = 1'b0;
        {read_i, write_i, hosc_tick_i, lrc_tick_i, timer_wake_i} = 5'h0;
        address_i = 12'h0;
        writedata_i = 32'h0;
        byteenable_i = 4'hf;
        high_clk_option_i = 3'h0;
        port_lvl_i = 8'h00;
        for (o = 0; o < 6; o++) begin
            @(posedge clock_i);
            resetn_i <= 1'b0;
            high_clk_option_i <= 3'(o);
            repeat (4) @(posedge clock_i);
            @(negedge clock_i);
            chk({cpu_run_o, slow_rc, op_mode_o}, 4'h4, "reset outputs");
            @(posedge clock_i);
            resetn_i <= 1'b1;
            tick(1'b1, 2048);
            chk(cpu_run_o, 1'b0, "run before warm-up");
            tick(1'b0, 2047);
            chk(cpu_run_o, 1'b0, "run too early");
            tick(1'b0, 1);
            chk({cpu_run_o, op_mode_o}, {1'b1, OMC_MODE_NORMAL}, "run after warm-up");
            chk({fast_rc, rtc_en, ext_en}, (o == 0) ? 3'h4 : (o == 1) ? 3'h6 : 3'h1,
                "fast source on");
            if (o == 0) begin
                rd(OMC_MODE_ADDR, 32'h0);
                bus(1'b1, OMC_MODE_ADDR, 32'hff);
                rd(OMC_MODE_ADDR, 32'h1e);
                chk({cpu_run_o, slow_sel, op_mode_o}, {2'h3, OMC_MODE_SLOW}, "reserved");
                rd(12'h000, 32'h0);
                bus(1'b1, OMC_MODE_ADDR, 32'h00);
                repeat (2) @(negedge clock_i);
                chk({slow_sel, op_mode_o}, {1'b0, OMC_MODE_NORMAL}, "normal clock");
                // unmapped write and a write without lane 0 must both be ignored
                bus(1'b1, 12'h000, 32'h04);
                @(posedge clock_i);
                byteenable_i <= 4'he;
                bus(1'b1, OMC_MODE_ADDR, 32'h04);
                rd(OMC_MODE_ADDR, 32'h0);
                @(posedge clock_i);
                byteenable_i <= 4'hf;
            end
            bus(1'b1, OMC_MODE_ADDR, 32'h02);
            repeat (2) @(negedge clock_i);
            chk({fast_rc, rtc_en, ext_en, slow_rc, cpu_run_o}, 5'h3, "stop");
            bus(1'b1, OMC_MODE_ADDR, 32'h0c);
            repeat (2) @(negedge clock_i);
            chk({fast_rc, rtc_en, ext_en, slow_rc, cpu_run_o, op_mode_o},
                {5'h0, OMC_MODE_PDOWN}, "power down");
            pulse_timer();
            repeat (6) @(negedge clock_i);
            chk(op_mode_o, OMC_MODE_PDOWN, "timer ignored in sleep");
            @(posedge clock_i);
            port_lvl_i <= ~port_lvl_i;
            for (n = 0; n < 50 && (fast_rc | ext_en) !== 1'b1; n++) @(negedge clock_i);
            chk(fast_rc | ext_en, 1'b1, "wake restarts oscillator");
            tick(1'b0, (o >= 3) ? 2047 : 31);
            chk(cpu_run_o, 1'b0, "wake warm-up early");
            tick(1'b0, 1);
            chk({cpu_run_o, op_mode_o}, {1'b1, OMC_MODE_NORMAL}, "wake");
            rd(OMC_MODE_ADDR, 32'h0);
            bus(1'b1, OMC_MODE_ADDR, o[0] ? 32'h10 : 32'h14);
            repeat (2) @(negedge clock_i);
            chk({cpu_run_o, op_mode_o}, {1'b0, OMC_MODE_GREEN}, "green");
            if (!o[0]) chk(slow_rc, 1'b1, "green clock kept");
            if (o[0]) begin
                @(posedge clock_i);
                port_lvl_i <= ~port_lvl_i;
            end else pulse_timer();
            wait_run();
            chk(op_mode_o, o[0] ? OMC_MODE_NORMAL : OMC_MODE_SLOW, "green return");
            rd(OMC_MODE_ADDR, o[0] ? 32'h0 : 32'h04);
        end
        tally_and_finish();
    end
endmodule : test_oscillator_mode_control
